//--- hw/asap_port.sv
/*
 * serial write port with chip addressing and register file of the attenuator.
 * assumes serial clock, data, strobe, straps and preset pin are asynchronous
 * and the serial clock is well below a quarter of the 20 MHz system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module asap_port
   import asap_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic SCLK_I,
   input wire logic SDATA_I,
   input wire logic LOAD_STROBE_I,
   input wire logic CHIP_STRAP_BIT0_I,
   input wire logic CHIP_STRAP_BIT1_I,
   input wire logic CHIP_STRAP_BIT2_I,
   input wire logic FAST_PRESET_SELECT_I,
   output logic [6:0] CORE_WORD_O,
   output logic [6:0] QUARTER_DB_O,
   output logic PRESET_ACTIVE_O,
   output logic [7:0] ATTEN_O,
   output logic [7:0] CONFIG_O,
   output logic [7:0] PRESET_LEVEL_O,
   output logic [2:0] CHIP_ID_O,
   output logic FRAME_DROP_O
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic sclk;
   logic sdata;
   logic strobe;
   logic fsel;
   logic [2:0] strap;
   asap_sync #(.W(4), .INIT(4'h2)) u_sync_link (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .d_i({SCLK_I, SDATA_I, LOAD_STROBE_I, FAST_PRESET_SELECT_I}),
      .q_o({sclk, sdata, strobe, fsel})
   );
   asap_sync #(.W(3), .INIT(STRAP_FLOAT_ID)) u_sync_strap (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .d_i({CHIP_STRAP_BIT2_I, CHIP_STRAP_BIT1_I, CHIP_STRAP_BIT0_I}),
      .q_o(strap)
   );

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      asap_state_t st;
      logic sclk_d;
      logic strobe_d;
      logic [15:0] shreg;
      logic [CNT_W-1:0] cnt;
      logic match;
      logic [3:0] tgt;
      logic [7:0] payload;
      logic [7:0] atten;
      logic [7:0] cfg;
      logic [7:0] preset;
      logic drop;
   } asap_port_t;
   asap_port_t r;
   asap_port_t next_r;

   function automatic logic id_match(input logic [15:0] f, input logic [2:0] id);
      id_match = (f[ADDR_CHIP_LSB +: 3] == id) && !f[ADDR_RSV_BIT];
   endfunction : id_match

   // ****************************************
   // frame receive and register load
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.sclk_d = sclk;
      next_r.strobe_d = strobe;
      next_r.drop = 1'b0;
      case (r.st)
         ASAP_IDLE: begin
            if (r.strobe_d && !strobe) begin
               next_r.st = ASAP_SHIFT;
               next_r.cnt = '0;
            end
         end
         ASAP_SHIFT: begin
            if (strobe) begin
               if (r.cnt == CNT_W'(FRAME_BITS)) begin
                  next_r.match = id_match(r.shreg, strap);
                  next_r.tgt = r.shreg[ADDR_REG_LSB +: 4];
                  next_r.payload = r.shreg[7:0];
                  next_r.st = ASAP_HELD;
               end else begin
                  next_r.drop = 1'b1;
                  next_r.st = ASAP_IDLE;
               end
            end else if (sclk && !r.sclk_d) begin
               next_r.shreg = {sdata, r.shreg[15:1]};
               if (r.cnt != CNT_W'(FRAME_BITS + 1)) begin
                  next_r.cnt = r.cnt + CNT_W'(1);
               end
            end
         end
         ASAP_HELD: begin
            if (!strobe) begin
               next_r.st = ASAP_SHIFT;
               next_r.cnt = '0;
               if (r.match) begin
                  case (r.tgt)
                     REG_ATTEN: next_r.atten = r.payload;
                     REG_CONFIG: next_r.cfg = r.payload;
                     REG_PRESET: next_r.preset = r.payload;
                     default: next_r.drop = 1'b1;
                  endcase
               end else begin
                  next_r.drop = 1'b1;
               end
            end
         end
         default: begin
            next_r.st = ASAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         r <= '{st: ASAP_IDLE, sclk_d: 1'b0, strobe_d: 1'b1, shreg: 16'h0000,
                cnt: '0, match: 1'b0, tgt: 4'h0, payload: 8'h00,
                atten: ATTEN_RESET, cfg: CONFIG_RESET, preset: PRESET_RESET,
                drop: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // core word selection
   // ****************************************
   asap_core_sel u_sel (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .atten_i(r.atten),
      .config_i(r.cfg),
      .preset_i(r.preset),
      .preset_sel_i(fsel),
      .core_word_o(CORE_WORD_O),
      .quarter_db_o(QUARTER_DB_O),
      .preset_active_o(PRESET_ACTIVE_O)
   );

   assign ATTEN_O = r.atten;
   assign CONFIG_O = r.cfg;
   assign PRESET_LEVEL_O = r.preset;
   assign CHIP_ID_O = strap;
   assign FRAME_DROP_O = r.drop;
endmodule : asap_port
`default_nettype wire

//--- hw/asap_pkg.sv
/*
 * constants, state and field layout of the addressed serial attenuator port.
 * assumes a single 20 MHz system clock; all serial pins arrive asynchronously.
 */
// Function
// - every write frame is sixteen bits
// - bits arrive least significant first
// - data byte precedes address byte
// - data bit 7 reserved, bits 6-0 value
// - address bits 2-0 chip, 7-4 register
// - strobe low opens frame, shifts only then
// - rising strobe compares chip id to straps
// - on match load byte at strobe fall
// - mismatch discards frame, registers unchanged
// - straps form binary id, strap2 msb
// - floating straps read binary 110
// - preset select pin switches attenuation three system clocks later
// - address 0 atten, 1 config, 2 preset
// - reset loads 7f atten/preset, config zero
// - config bit1 and pin select preset word
// - word bits weight 16 down to 0.25 dB
package asap_pkg;
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned CNT_W = 5;
   localparam logic [3:0] REG_ATTEN = 4'h0;
   localparam logic [3:0] REG_CONFIG = 4'h1;
   localparam logic [3:0] REG_PRESET = 4'h2;
   localparam logic [7:0] ATTEN_RESET = 8'h7f;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] PRESET_RESET = 8'h7f;
   localparam int unsigned CFG_PRESET_EN_BIT = 1;
   localparam int unsigned CFG_POINTER_BIT = 0;
   localparam int unsigned ADDR_CHIP_LSB = 8;
   localparam int unsigned ADDR_RSV_BIT = 11;
   localparam int unsigned ADDR_REG_LSB = 12;
   localparam logic [2:0] STRAP_FLOAT_ID = 3'h6;
   typedef enum logic [2:0] {
      ASAP_IDLE = 3'b001,
      ASAP_SHIFT = 3'b010,
      ASAP_HELD = 3'b100
   } asap_state_t;
endpackage : asap_pkg

//--- hw/asap_sync.sv
/*
 * two flip-flop synchroniser for a bus of asynchronous pins.
 * assumes one clock; first stage is read only by the second.
 */
`timescale 1ns/1ns
`default_nettype none
module asap_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } asap_sync_t;
   asap_sync_t r;
   asap_sync_t next_r;
   always_comb begin
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '{s1: INIT, s2: INIT};
      end else begin
         r <= next_r;
      end
   end
   assign q_o = r.s2;
endmodule : asap_sync
`default_nettype wire

//--- hw/asap_core_sel.sv
/*
 * selects the word driving the attenuator core and decodes it to quarter-dB steps.
 * assumes registered inputs on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module asap_core_sel
   import asap_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] atten_i,
   input wire logic [7:0] config_i,
   input wire logic [7:0] preset_i,
   input wire logic preset_sel_i,
   output logic [6:0] core_word_o,
   output logic [6:0] quarter_db_o,
   output logic preset_active_o
);
   typedef struct packed {
      logic [6:0] word;
      logic [6:0] qdb;
      logic act;
   } asap_sel_t;
   asap_sel_t r;
   asap_sel_t next_r;
   always_comb begin
      next_r.act = config_i[CFG_PRESET_EN_BIT] & preset_sel_i;
      next_r.word = next_r.act ? preset_i[6:0] : atten_i[6:0];
      next_r.qdb = next_r.word;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '{word: ATTEN_RESET[6:0], qdb: ATTEN_RESET[6:0], act: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   assign core_word_o = r.word;
   assign quarter_db_o = r.qdb;
   assign preset_active_o = r.act;
endmodule : asap_core_sel
`default_nettype wire

//--- dv/asap_ctrl_model.sv
/*
 * serial controller model driving clock, data and load strobe.
 * assumes each send starts at a falling mclk edge; link clock 400 ns.
 */
`timescale 1ns/1ns
`default_nettype none
module asap_ctrl_model (
   output logic sclk_o,
   output logic sdata_o,
   output logic strobe_o
);
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      strobe_o = 1'b1;
   end
   // n bits lsb first, data byte then address byte
   task automatic send(input logic [15:0] f, input int n);
      strobe_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdata_o = f[i];
         #200 sclk_o = 1'b1;
         #200 sclk_o = 1'b0;
      end
      sdata_o = ~sdata_o;
      #200 strobe_o = 1'b1;
      #400 strobe_o = 1'b0;
      #400;
   endtask : send
endmodule : asap_ctrl_model
`default_nettype wire

//--- dv/asap_port_checker.sv
/*
 * assertions on the pins of the attenuator port.
 * assumes binding to asap_port, one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
module asap_port_checker (
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic LOAD_STROBE_I,
   input wire logic FAST_PRESET_SELECT_I,
   input wire logic [6:0] CORE_WORD_O,
   input wire logic [6:0] QUARTER_DB_O,
   input wire logic PRESET_ACTIVE_O,
   input wire logic [7:0] ATTEN_O,
   input wire logic [7:0] CONFIG_O,
   input wire logic [7:0] PRESET_LEVEL_O,
   input wire logic FRAME_DROP_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   reset_values_a: assert property ($rose(RST_N_I) |-> {ATTEN_O, CONFIG_O, PRESET_LEVEL_O} == 24'h7f007f)
      else $error("reset values wrong");
   atten_drives_a: assert property (!PRESET_ACTIVE_O && $past(!PRESET_ACTIVE_O) && $stable(ATTEN_O)
      |-> CORE_WORD_O == ATTEN_O[6:0]) else $error("core not atten");
   preset_drives_a: assert property (PRESET_ACTIVE_O && $past(PRESET_ACTIVE_O) && $stable(PRESET_LEVEL_O)
      |-> CORE_WORD_O == PRESET_LEVEL_O[6:0]) else $error("core not preset");
   quarter_step_a: assert property ($stable(CORE_WORD_O) |-> QUARTER_DB_O == CORE_WORD_O)
      else $error("step value wrong");
   drop_keeps_a: assert property (FRAME_DROP_O |=> $stable({ATTEN_O, CONFIG_O, PRESET_LEVEL_O})[*4])
      else $error("dropped frame stored");
   load_low_a: assert property ($changed({ATTEN_O, CONFIG_O, PRESET_LEVEL_O}) |-> !$past(LOAD_STROBE_I, 2))
      else $error("load without low strobe");
   one_reg_a: assert property ($onehot0({$changed(ATTEN_O), $changed(CONFIG_O), $changed(PRESET_LEVEL_O)}))
      else $error("several registers changed");
   preset_off_a: assert property (!CONFIG_O[1] && !$past(CONFIG_O[1]) |-> !PRESET_ACTIVE_O)
      else $error("preset active while off");
   preset_on_a: assert property ((CONFIG_O[1] && FAST_PRESET_SELECT_I)[*5] |-> PRESET_ACTIVE_O)
      else $error("preset not active");
   cover property (FRAME_DROP_O);
   cover property ($changed(ATTEN_O));
   cover property ($rose(PRESET_ACTIVE_O));
endmodule : asap_port_checker
bind asap_port asap_port_checker chk_i (.*);
`default_nettype wire

//--- dv/addressed_serial_attenuator_port_test.sv
/*
 * self-checking bench of the attenuator port.
 * assumes controller model and checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module addressed_serial_attenuator_port_test;
   import asap_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, sdata, strobe, drop, act;
   logic [2:0] strap = 3'h6;
   logic [2:0] id;
   logic pin = 1'b0;
   logic [6:0] core, qdb;
   logic [7:0] atten, cfg, pre;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_drop = 0;
   always #25 mclk = ~mclk;
   always @(posedge mclk) if (drop === 1'b1) n_drop++;
   asap_ctrl_model ctl (.sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe));
   asap_port dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCLK_I(sclk), .SDATA_I(sdata), .LOAD_STROBE_I(strobe),
      .CHIP_STRAP_BIT0_I(strap[0]), .CHIP_STRAP_BIT1_I(strap[1]), .CHIP_STRAP_BIT2_I(strap[2]),
      .FAST_PRESET_SELECT_I(pin), .CORE_WORD_O(core), .QUARTER_DB_O(qdb), .PRESET_ACTIVE_O(act),
      .ATTEN_O(atten), .CONFIG_O(cfg), .PRESET_LEVEL_O(pre), .CHIP_ID_O(id), .FRAME_DROP_O(drop));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] f, input int n);
      @(negedge mclk);
      ctl.send(f, n);
   endtask : wr
   task automatic t_reset;
      chk("atten", ATTEN_RESET, atten);
      chk("config", CONFIG_RESET, cfg);
      chk("preset", PRESET_RESET, pre);
      chk("id", {5'h0, STRAP_FLOAT_ID}, {5'h0, id});
      chk("active", 8'h00, {7'h0, act});
      $display("done reset");
   endtask : t_reset
   task automatic t_write;
      wr(16'h06a5, 16);
      chk("atten", 8'ha5, atten);
      chk("core", 8'h25, {1'b0, core});
      chk("step", 8'h25, {1'b0, qdb});
      $display("done write");
   endtask : t_write
   task automatic t_refuse;
      wr(16'h0533, 16);
      wr(16'h0e33, 16);
      wr(16'h3633, 16);
      wr(16'h0633, 15);
      chk("atten", 8'ha5, atten);
      chk("config", 8'h00, cfg);
      chk("preset", 8'h7f, pre);
      chk("drops", 8'h04, n_drop[7:0]);
      $display("done refuse");
   endtask : t_refuse
   task automatic t_preset;
      wr(16'h2611, 16);
      wr(16'h1602, 16);
      pin = 1'b1;
      repeat (8) @(negedge mclk);
      chk("core", 8'h11, {1'b0, core});
      chk("active", 8'h01, {7'h0, act});
      pin = 1'b0;
      repeat (8) @(negedge mclk);
      chk("core", 8'h25, {1'b0, core});
      chk("active", 8'h00, {7'h0, act});
      $display("done preset");
   endtask : t_preset
   task automatic t_id0;
      strap = 3'h0;
      wr(16'h0040, 16);
      chk("atten", 8'h40, atten);
      $display("done id");
   endtask : t_id0
   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   initial begin
      #300000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_write();
      t_refuse();
      t_preset();
      t_id0();
      complete_run();
   end
endmodule : addressed_serial_attenuator_port_test
`default_nettype wire
